// ==== verification/pic_sync_src.sv ====
// model of the vertical sync source that drives the coast gate pin
`timescale 1ns/1ns
module pic_sync_src (
  input  wire logic ref_clk,
  input  wire logic level_cmd,
  output logic      coast_gate_pin
);
  // pin moves just after a clock edge, like a registered sync source
  initial coast_gate_pin = 1'b0;
  always @(posedge ref_clk) coast_gate_pin <= level_cmd;
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the pll input control register bank
`timescale 1ns/1ns
module tb_top;
  import pic_pkg::*;
  logic       ref_clk, rst_n, wr, rd, pin_cmd;
  logic [7:0] addr, wdata, rdata;
  logic       coast_gate_pin, detector_active;
  pic_insel_t insel;
  pic_cal_t   cal;
  int         num_errors, check_count, cyc;

  pic_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .coast_gate_pin(coast_gate_pin), .insel(insel), .cal(cal), .detector_active(detector_active));
  pic_sync_src src (.ref_clk(ref_clk), .level_cmd(pin_cmd), .coast_gate_pin(coast_gate_pin));

  // clock and hang ceiling
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  // compare and bus tasks
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pin_cmd = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(PIC_OFS_INSEL, 8'h21);
    rd_chk(PIC_OFS_BCOMP, 8'h77);
    rd_chk(PIC_OFS_CAL1, 8'h2d);
    rd_chk(PIC_OFS_CAL2, 8'ha5);
    wr_reg(PIC_OFS_CAL1, 8'hc0);
    chk({5'h00, cal.converter_data_delay}, 8'h01);
    chk({2'h0, cal.green_clock_delay, cal.red_clock_delay}, 8'h00);
    rd_chk(PIC_OFS_CAL1, 8'h40);
    wr_reg(PIC_OFS_CAL2, 8'h1a);
    chk({5'h00, cal.converter_data_delay}, 8'h07);
    chk({5'h00, cal.blue_clock_delay}, 8'h02);
    chk({5'h00, cal.bandgap_trim}, 8'h00);
    wr_reg(PIC_OFS_BCOMP, 8'h3c);
    chk({cal.blue_offset_b, cal.blue_offset_a}, 8'h3c);
    wr_reg(8'h01, 8'hff);
    rd_chk(8'h01, 8'h00);
    rd_chk(PIC_OFS_INSEL, 8'h21);
    // every trigger code, other bits toggled both ways
    for (int t = 0; t < 4; t++) begin
      wr_reg(PIC_OFS_INSEL, {t[1:0], 6'h3e ^ {6{t[0]}}});
      chk(insel, {t[1:0], 6'h3e ^ {6{t[0]}}});
    end
    // all run enable, polarity and pin combinations
    for (int k = 0; k < 8; k++) begin
      wr_reg(PIC_OFS_INSEL, {6'h20, k[1:0]});
      pin_cmd <= k[2];
      repeat (3) @(posedge ref_clk);
      #1 chk({7'h00, detector_active}, {7'h00, k[0] | (k[2] == k[1])});
    end
    // reset in mid-run restores defaults
    wr_reg(PIC_OFS_CAL2, 8'h00);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk(insel, 8'h21);
    chk({5'h00, cal.bandgap_trim}, 8'h05);
    rd_chk(PIC_OFS_CAL2, 8'ha5);
    stop_test();
  end
endmodule

// ==== verilog/pic_pkg.sv ====
// constants and types for the pll input control register bank
// Function
// R1: two-bit sync trigger select picks one of four schmitt triggers; 2 recommended.
// R2: detector input select: 0 horizontal sync, 1 oscillator reference (default).
// R3: divider load timing: 0 load at pll reset, 1 at next scan line.
// R4: feedback edge polarity: 0 rising edge, 1 falling edge.
// R5: reference edge polarity: 0 rising edge, 1 falling edge.
// R6: coast pin polarity: 0 pin active high, 1 pin active low.
// R7: coast pin polarity has no effect while detector run enable is 1.
// R8: run enable 0: detector held off while coast pin is active.
// R9: run enable 1 (reset value): detector runs, coast pin ignored.
// R10: any reset returns every register bit to its default.
// R11: blue comparator offset holds two four-bit codes, both reset to 7.
// R12: converter data delay split: lsb at cal one bit 6, msbs cal two 4-3.
// R13: clock delays green 5-3, red 2-0 of cal one, blue 2-0 cal two; reset 5.
// R14: reserved bits read zero and writes to them have no effect.
// R15: host programs select and polarity bits before releasing pll reset.
package pic_pkg;
  localparam int          PIC_AW            = 8;
  localparam int          PIC_DW            = 8;
  localparam logic [7:0]  PIC_OFS_INSEL     = 8'h00;
  localparam logic [7:0]  PIC_OFS_BCOMP     = 8'h3a;
  localparam logic [7:0]  PIC_OFS_CAL1      = 8'h3b;
  localparam logic [7:0]  PIC_OFS_CAL2      = 8'h3c;
  localparam logic [7:0]  PIC_RST_INSEL     = 8'h21;
  localparam logic [7:0]  PIC_RST_BCOMP     = 8'h77;
  localparam logic [7:0]  PIC_RST_CAL1      = 8'h2d;
  localparam logic [7:0]  PIC_RST_CAL2      = 8'ha5;
  localparam logic [7:0]  PIC_MASK_CAL1     = 8'h7f;
  localparam logic [1:0]  PIC_TRIG_RECOMMEND = 2'h2;

  // decoded fields of the input select register
  typedef struct packed {
    logic [1:0] sync_trigger_sel;
    logic       detector_input_sel;
    logic       divider_load_timing;
    logic       feedback_edge_pol;
    logic       reference_edge_pol;
    logic       coast_pin_polarity;
    logic       detector_run_enable;
  } pic_insel_t;

  // calibration outputs
  typedef struct packed {
    logic [3:0] blue_offset_b;
    logic [3:0] blue_offset_a;
    logic [2:0] converter_data_delay;
    logic [2:0] green_clock_delay;
    logic [2:0] red_clock_delay;
    logic [2:0] blue_clock_delay;
    logic [2:0] bandgap_trim;
  } pic_cal_t;
endpackage

// ==== verilog/pic_regs.sv ====
// pll input control register bank with detector gating
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module pic_regs
  import pic_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [PIC_AW-1:0] addr,
  input  wire logic [PIC_DW-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [PIC_DW-1:0] rdata,
  input  wire logic              coast_gate_pin,
  output pic_insel_t             insel,
  output pic_cal_t               cal,
  output logic                   detector_active
);
  logic [7:0] insel_reg;
  logic [7:0] bcomp_reg;
  logic [7:0] cal1_reg;
  logic [7:0] cal2_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       det_reg;
  logic       det_next;

  // register map; offsets and reset values live in the package
  //   input select  - trigger, detector input, load timing, edge polarities,
  //                   coast pin polarity and detector run enable
  //   blue offsets  - two four-bit comparator offset codes
  //   calibration 1 - reserved top bit, data delay lsb, green and red delays
  //   calibration 2 - bandgap trim, data delay msbs, blue delay
  // plain strobe port: one cycle per access, no wait states,
  // read data registered and shown only in the cycle after the read strobe

  // decode and routing below are written for byte-wide address and data
  if (PIC_AW != 8 || PIC_DW != 8) begin : g_size_check
    $error("register bank is built for eight bit address and data");
  end

  // address decode
  wire logic hit_insel = (addr == PIC_OFS_INSEL);
  wire logic hit_bcomp = (addr == PIC_OFS_BCOMP);
  wire logic hit_cal1  = (addr == PIC_OFS_CAL1);
  wire logic hit_cal2  = (addr == PIC_OFS_CAL2);

  // read mux; unmapped reads give zero
  assign rdata_next = rd ? ((hit_insel ? insel_reg : 8'h00) |
                            (hit_bcomp ? bcomp_reg : 8'h00) |
                            (hit_cal1  ? cal1_reg  : 8'h00) | // [R14]
                            (hit_cal2  ? cal2_reg  : 8'h00)) : 8'h00;

  // coast gating: pin active level per polarity, ignored while run enabled
  wire logic pin_active = coast_gate_pin ^ insel_reg[1];  // [R6]
  assign det_next = insel_reg[0] | ~pin_active;           // [R7] [R8] [R9]

  // register writes and defaults
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      insel_reg <= PIC_RST_INSEL;                          // [R10]
      bcomp_reg <= PIC_RST_BCOMP;                          // [R11]
      cal1_reg  <= PIC_RST_CAL1;                           // [R13]
      cal2_reg  <= PIC_RST_CAL2;                           // [R12]
      rdata_reg <= 8'h00;
      det_reg   <= 1'b1;
    end else begin
      if (wr && hit_insel) insel_reg <= wdata;
      if (wr && hit_bcomp) bcomp_reg <= wdata;
      if (wr && hit_cal1)  cal1_reg  <= wdata & PIC_MASK_CAL1; // [R14]
      if (wr && hit_cal2)  cal2_reg  <= wdata;
      rdata_reg <= rdata_next;
      det_reg   <= det_next;
    end
  end

  assign rdata           = rdata_reg;
  assign detector_active = det_reg;
  // field routing straight from register flops
  assign insel = pic_insel_t'(insel_reg);                  // [R1] [R2] [R3] [R4] [R5]
  assign cal.blue_offset_b        = bcomp_reg[7:4];        // [R11]
  assign cal.blue_offset_a        = bcomp_reg[3:0];
  assign cal.converter_data_delay = {cal2_reg[4:3], cal1_reg[6]}; // [R12]
  assign cal.green_clock_delay    = cal1_reg[5:3];         // [R13]
  assign cal.red_clock_delay      = cal1_reg[2:0];
  assign cal.blue_clock_delay     = cal2_reg[2:0];
  assign cal.bandgap_trim         = cal2_reg[7:5];

  // assertions
  property p_coast_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (!insel_reg[0] && (coast_gate_pin ^ insel_reg[1])) |=> !detector_active;
  endproperty
  a_coast_hold: assert property (p_coast_hold) else $error("detector not held during coast"); // [R8]

  property p_run_enable;
    @(posedge ref_clk) disable iff (!rst_n) insel_reg[0] |=> detector_active;
  endproperty
  a_run_enable: assert property (p_run_enable) else $error("detector off while run enabled"); // [R9]

  property p_pol_ignored;
    @(posedge ref_clk) disable iff (!rst_n)
      (insel_reg[0] && $changed(insel_reg[1])) |=> detector_active;
  endproperty
  a_pol_ignored: assert property (p_pol_ignored) else $error("polarity acted while enabled"); // [R7]

  property p_pin_high;
    @(posedge ref_clk) disable iff (!rst_n)
      (!insel_reg[0] && !insel_reg[1] && !coast_gate_pin) |=> detector_active;
  endproperty
  a_pin_high: assert property (p_pin_high) else $error("active high pin misread"); // [R6]

  property p_readback;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && hit_cal1) |=> (rdata == cal1_reg && !rdata[7]);
  endproperty
  a_readback: assert property (p_readback) else $error("cal one readback wrong"); // [R14]

  property p_write_insel;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_insel) |=> (insel == pic_insel_t'($past(wdata)));
  endproperty
  a_write_insel: assert property (p_write_insel) else $error("input select not written"); // [R2]

  property p_write_cal2;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_cal2) |=> (cal.converter_data_delay[2:1] == $past(wdata[4:3])
                            && cal.blue_clock_delay == $past(wdata[2:0]));
  endproperty
  a_write_cal2: assert property (p_write_cal2) else $error("cal two fields wrong"); // [R12]

  property p_write_bcomp;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_bcomp) |=> ({cal.blue_offset_b, cal.blue_offset_a} == $past(wdata));
  endproperty
  a_write_bcomp: assert property (p_write_bcomp) else $error("offset codes wrong"); // [R11]

  property p_unmapped;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && !hit_insel && !hit_bcomp && !hit_cal1 && !hit_cal2) |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [R14]

  // unmapped writes leave every register alone
  // a decode overlap here would silently retune the loop
  property p_unmapped_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && !hit_insel && !hit_bcomp && !hit_cal1 && !hit_cal2)
        |=> ($stable(insel_reg) && $stable(bcomp_reg) && $stable(cal1_reg) && $stable(cal2_reg));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed a register"); // [R14]

  // registers move only on a write strobe
  // reads must never disturb the stored settings
  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !wr |=> ($stable(insel_reg) && $stable(bcomp_reg) && $stable(cal1_reg) && $stable(cal2_reg));
  endproperty
  a_hold: assert property (p_hold) else $error("register moved without a write"); // [R2]

  // a write elsewhere leaves the input select untouched
  property p_insel_keep;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && !hit_insel) |=> $stable(insel_reg);
  endproperty
  a_insel_keep: assert property (p_insel_keep) else $error("input select hit by foreign write"); // [R2]

  // a write elsewhere leaves the offset codes untouched
  property p_bcomp_keep;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && !hit_bcomp) |=> $stable(bcomp_reg);
  endproperty
  a_bcomp_keep: assert property (p_bcomp_keep) else $error("offset codes hit by foreign write"); // [R11]

  // a write elsewhere leaves calibration one untouched
  property p_cal1_keep;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && !hit_cal1) |=> $stable(cal1_reg);
  endproperty
  a_cal1_keep: assert property (p_cal1_keep) else $error("cal one hit by foreign write"); // [R13]

  // a write elsewhere leaves calibration two untouched
  property p_cal2_keep;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && !hit_cal2) |=> $stable(cal2_reg);
  endproperty
  a_cal2_keep: assert property (p_cal2_keep) else $error("cal two hit by foreign write"); // [R12]

  // one edge into reset the input select shows its default
  // checked a cycle late so the first async reset has settled
  property p_rst_insel;
    @(posedge ref_clk) !rst_n |=> (insel_reg == PIC_RST_INSEL);
  endproperty
  a_rst_insel: assert property (p_rst_insel) else $error("input select default wrong"); // [R10]

  // offset codes default
  property p_rst_bcomp;
    @(posedge ref_clk) !rst_n |=> (bcomp_reg == PIC_RST_BCOMP);
  endproperty
  a_rst_bcomp: assert property (p_rst_bcomp) else $error("offset default wrong"); // [R10]

  // calibration one default
  property p_rst_cal1;
    @(posedge ref_clk) !rst_n |=> (cal1_reg == PIC_RST_CAL1);
  endproperty
  a_rst_cal1: assert property (p_rst_cal1) else $error("cal one default wrong"); // [R10]

  // calibration two default
  property p_rst_cal2;
    @(posedge ref_clk) !rst_n |=> (cal2_reg == PIC_RST_CAL2);
  endproperty
  a_rst_cal2: assert property (p_rst_cal2) else $error("cal two default wrong"); // [R10]

  // detector runs out of reset
  property p_rst_det;
    @(posedge ref_clk) !rst_n |=> detector_active;
  endproperty
  a_rst_det: assert property (p_rst_det) else $error("detector off after reset"); // [R9]

  // read data idle out of reset
  property p_rst_rdata;
    @(posedge ref_clk) !rst_n |=> (rdata == 8'h00);
  endproperty
  a_rst_rdata: assert property (p_rst_rdata) else $error("read data not idle after reset"); // [R10]

  // input select readback
  // compared with the value held at the read edge
  property p_read_insel;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && hit_insel) |=> (rdata == $past(insel_reg));
  endproperty
  a_read_insel: assert property (p_read_insel) else $error("input select readback wrong"); // [R2]

  // offset codes readback
  property p_read_bcomp;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && hit_bcomp) |=> (rdata == $past(bcomp_reg));
  endproperty
  a_read_bcomp: assert property (p_read_bcomp) else $error("offset readback wrong"); // [R11]

  // calibration two readback
  property p_read_cal2;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && hit_cal2) |=> (rdata == $past(cal2_reg));
  endproperty
  a_read_cal2: assert property (p_read_cal2) else $error("cal two readback wrong"); // [R12]

  // reserved top bit of calibration one never stores a one
  // a stray one there would read back and break software masks
  property p_cal1_reserved;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_cal1 && wdata[7]) |=> !cal1_reg[7];
  endproperty
  a_cal1_reserved: assert property (p_cal1_reserved) else $error("reserved bit stored"); // [R14]

  // calibration one fields land where they belong
  // delay lsb is split off into the combined data delay code
  property p_write_cal1;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_cal1) |=> (cal.green_clock_delay == $past(wdata[5:3])
                            && cal.red_clock_delay == $past(wdata[2:0])
                            && cal.converter_data_delay[0] == $past(wdata[6]));
  endproperty
  a_write_cal1: assert property (p_write_cal1) else $error("cal one fields wrong"); // [R13]

  // trigger select follows the written code
  // every code is legal, two being the usual pick
  property p_trig_route;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_insel) |=> (insel.sync_trigger_sel == $past(wdata[7:6]));
  endproperty
  a_trig_route: assert property (p_trig_route) else $error("trigger select wrong"); // [R1]

  // detector input source follows the written bit
  property p_src_route;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_insel) |=> (insel.detector_input_sel == $past(wdata[5]));
  endproperty
  a_src_route: assert property (p_src_route) else $error("detector input select wrong"); // [R2]

  // divider load timing follows the written bit
  property p_load_route;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_insel) |=> (insel.divider_load_timing == $past(wdata[4]));
  endproperty
  a_load_route: assert property (p_load_route) else $error("load timing wrong"); // [R3]

  // feedback edge polarity follows the written bit
  property p_fb_route;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_insel) |=> (insel.feedback_edge_pol == $past(wdata[3]));
  endproperty
  a_fb_route: assert property (p_fb_route) else $error("feedback polarity wrong"); // [R4]

  // reference edge polarity follows the written bit
  // wrong edge here shifts the recovered clock by half a line
  property p_ref_route;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && hit_insel) |=> (insel.reference_edge_pol == $past(wdata[2]));
  endproperty
  a_ref_route: assert property (p_ref_route) else $error("reference polarity wrong"); // [R5]

  // active low pin: low level coasts the detector
  // inverted sense is the usual hazard with sync sources
  property p_low_coast;
    @(posedge ref_clk) disable iff (!rst_n)
      (!insel_reg[0] && insel_reg[1] && !coast_gate_pin) |=> !detector_active;
  endproperty
  a_low_coast: assert property (p_low_coast) else $error("active low pin did not coast"); // [R6]

  // active low pin: high level lets the detector run
  property p_low_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      (!insel_reg[0] && insel_reg[1] && coast_gate_pin) |=> detector_active;
  endproperty
  a_low_idle: assert property (p_low_idle) else $error("active low pin misread"); // [R6]

  // pin toggles while run enabled never stop the detector
  // guards against the gate leaking past the override
  property p_pin_ignored;
    @(posedge ref_clk) disable iff (!rst_n)
      (insel_reg[0] && $changed(coast_gate_pin)) |=> detector_active;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("pin acted while run enabled"); // [R9]

  // with run enable clear the detector tracks the pin each cycle
  // one cycle of latency, no extra filtering
  property p_det_follow;
    @(posedge ref_clk) disable iff (!rst_n)
      !insel_reg[0] |=> (detector_active
                         == ($past(coast_gate_pin) == $past(insel_reg[1])));
  endproperty
  a_det_follow: assert property (p_det_follow) else $error("detector did not track the pin"); // [R8]

  // read data stays at zero outside the cycle after a read
  // lets a shared read bus be or-combined downstream
  property p_rdata_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      !rd |=> (rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle"); // [R14]

  c_coast: cover property (@(posedge ref_clk) disable iff (!rst_n) !detector_active);
  c_trig2: cover property (@(posedge ref_clk) disable iff (!rst_n)
                           insel.sync_trigger_sel == PIC_TRIG_RECOMMEND);
  c_hsync: cover property (@(posedge ref_clk) disable iff (!rst_n) !insel.detector_input_sel);
  c_rdcal: cover property (@(posedge ref_clk) disable iff (!rst_n) rd && hit_cal2);
  c_lowpin: cover property (@(posedge ref_clk) disable iff (!rst_n) !insel_reg[0] && insel_reg[1]);
endmodule
